// >>> hw/dop_ctrl.sv
// Purpose: controller for one digital output point
// Assumes: commands and watchdog come from logic on mclk_i
// Notes:   registers on a plain port, read data one cycle after the read strobe
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "dop_params.svh"
module dop_ctrl #(
  parameter int TICK_CYCLES = `DOP_TICK_CYCLES
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire logic [`DOP_ADDR_W-1:0] addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rdata_o,
  input  wire logic                   cmd_valid_i,
  input  wire logic [7:0]             cmd_value_i,
  input  wire logic                   comm_watchdog_point_present_i,
  input  wire logic                   offline_i,
  input  wire logic                   cos_req_i,
  output logic                        rpt_valid_o,
  output logic                        rpt_high_o,
  output logic      [7:0]             rpt_value_o,
  output logic      [31:0]            chan_o,
  output logic                        irq_o
);
  function automatic logic [31:0] chan_mask(input logic [5:0] first, input logic [3:0] cnt);
    logic [31:0] m;
    m = (32'h0000_0001 << cnt) - 32'h0000_0001;
    return m << (first - 6'h01);
  endfunction

  dop_if pif ();
  dop_pulse u_pulse (.mclk_i(mclk_i), .rst_i(rst_i), .pif(pif));

  logic [5:0]           chan_r;
  logic [3:0]           cnt_r;
  logic                 pol_r;
  dop_pkg::dop_prio_t   prio_r;
  logic [7:0]           deact_r;
  logic [7:0]           act_r;
  logic [7:0]           fb_r;
  logic [15:0]          dur_r;
  logic [7:0]           maxint_r;
  logic [7:0]           value_r;
  logic [7:0]           value_nxt;
  logic                 on_r;
  logic                 on_nxt;
  logic                 cmd_go;
  logic                 offline_d_r;
  logic                 fb_go;
  logic [15:0]          crc;
  logic [15:0]          crc_ref_r;
  logic                 ref_set_r;
  logic                 cfg_chg_r;
  logic [7:0]           cond;
  logic [31:0]          sec_r;
  logic [31:0]          tick_cnt_r;
  logic [3:0]           tenth_r;
  logic                 tick_r;
  logic                 sec_go;
  logic [31:0]          last_chg_r;
  logic [7:0]           int_cnt_r;
  logic                 pend_r;
  logic                 low_slot_r;
  logic                 send_high;
  logic                 send_low;
  logic                 int_due;
  logic [3:0]           irq_stat_r;
  logic [3:0]           irq_mask_r;
  logic [3:0]           irq_ev;
  logic [7:0]           raw_bits;
  logic                 wr_cfg;
  logic                 wr_codes;
  logic                 wr_pulse;
  logic                 wr_maxint;
  logic                 wr_cmd;
  logic                 wr_crc;
  logic                 wr_istat;
  logic                 wr_imask;

  assign wr_cfg    = wr_i && addr_i == `DOP_OFF_CFG;
  assign wr_codes  = wr_i && addr_i == `DOP_OFF_CODES;
  assign wr_pulse  = wr_i && addr_i == `DOP_OFF_PULSE;
  assign wr_maxint = wr_i && addr_i == `DOP_OFF_MAXINT;
  assign wr_cmd    = wr_i && addr_i == `DOP_OFF_CMD;
  assign wr_crc    = wr_i && addr_i == `DOP_OFF_CRC;
  assign wr_istat  = wr_i && addr_i == `DOP_OFF_IRQ_STAT;
  assign wr_imask  = wr_i && addr_i == `DOP_OFF_IRQ_MASK;

  // configuration registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chan_r   <= `DOP_RST_CHAN;
      cnt_r    <= `DOP_RST_CNT;
      pol_r    <= 1'b0;
      prio_r   <= dop_pkg::DOP_PRIO_NO;
      deact_r  <= `DOP_CODE_OFF;
      act_r    <= `DOP_CODE_ON;
      fb_r     <= `DOP_CODE_OFF;
      dur_r    <= 16'h0000;
      maxint_r <= 8'h00;
    end else begin
      if (wr_cfg) begin
        if (wdata_i[`DOP_CFG_CHAN_LSB +: 6] >= `DOP_CHAN_MIN && wdata_i[`DOP_CFG_CHAN_LSB +: 6] <= `DOP_CHAN_MAX)
          chan_r <= wdata_i[`DOP_CFG_CHAN_LSB +: 6];
        if (wdata_i[`DOP_CFG_CNT_LSB +: 4] <= `DOP_CNT_MAX)
          cnt_r <= wdata_i[`DOP_CFG_CNT_LSB +: 4];
        pol_r <= wdata_i[`DOP_CFG_POL_BIT];
        if (wdata_i[`DOP_CFG_PRIO_LSB +: 2] != 2'h3)
          prio_r <= dop_pkg::dop_prio_t'(wdata_i[`DOP_CFG_PRIO_LSB +: 2]);
      end
      if (wr_codes) begin
        deact_r <= wdata_i[`DOP_CODE_DEACT_LSB +: 8];
        act_r   <= wdata_i[`DOP_CODE_ACT_LSB +: 8];
        fb_r    <= wdata_i[`DOP_CODE_FB_LSB +: 8];
      end
      if (wr_pulse) dur_r <= wdata_i[15:0];
      if (wr_maxint) maxint_r <= wdata_i[7:0];
    end
  end

  // command sources, highest first: fallback, register, command port, pulse end
  assign fb_go  = comm_watchdog_point_present_i && offline_i && !offline_d_r;
  assign cmd_go = fb_go || wr_cmd || cmd_valid_i || pif.done;

  always_comb begin
    value_nxt = value_r;
    if (fb_go) value_nxt = fb_r;
    else if (wr_cmd) value_nxt = wdata_i[7:0];
    else if (cmd_valid_i) value_nxt = cmd_value_i;
    else if (pif.done) value_nxt = deact_r;
    on_nxt = on_r;
    if (cmd_go && value_nxt == act_r) on_nxt = 1'b1;
    else if (cmd_go && value_nxt == deact_r) on_nxt = 1'b0;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      value_r     <= `DOP_CODE_OFF;
      on_r        <= 1'b0;
      offline_d_r <= 1'b0;
    end else begin
      value_r     <= value_nxt;
      on_r        <= on_nxt;
      offline_d_r <= offline_i;
    end
  end

  assign pif.load = on_nxt && !on_r;
  assign pif.stop = !on_nxt && on_r;
  assign pif.dur  = dur_r;
  assign pif.tick = tick_r;

  // physical channels and read-back of the driven channel bits
  always_ff @(posedge mclk_i) begin
    if (rst_i) chan_o <= 32'h0000_0000;
    else chan_o <= chan_mask(chan_r, cnt_r) & {32{on_r ^ pol_r}};
  end

  assign raw_bits = 8'((chan_o >> (chan_r - 6'h01)) & ((32'h0000_0001 << cnt_r) - 32'h0000_0001));

  // 100 ms tick and seconds time base
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
      tenth_r    <= 4'h0;
      sec_r      <= 32'h0000_0000;
    end else begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
      if (tick_cnt_r == 32'(TICK_CYCLES - 1)) tick_cnt_r <= 32'h0000_0000;
      else tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      if (tick_r) begin
        if (tenth_r == `DOP_TICKS_PER_SEC - 4'h1) begin
          tenth_r <= 4'h0;
          sec_r   <= sec_r + 32'h0000_0001;
        end else begin
          tenth_r <= tenth_r + 4'h1;
        end
      end
    end
  end
  assign sec_go = tick_r && tenth_r == `DOP_TICKS_PER_SEC - 4'h1;

  always_ff @(posedge mclk_i) begin
    if (rst_i) last_chg_r <= 32'h0000_0000;
    else if (value_nxt != value_r) last_chg_r <= sec_r;
  end

  // change-of-state reporting
  assign int_due   = maxint_r != 8'h00 && prio_r != dop_pkg::DOP_PRIO_NO && int_cnt_r >= maxint_r;
  assign send_high = cos_req_i && pend_r && prio_r == dop_pkg::DOP_PRIO_HIGH;
  assign send_low  = low_slot_r && pend_r && prio_r == dop_pkg::DOP_PRIO_LOW;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pend_r     <= 1'b0;
      low_slot_r <= 1'b0;
      int_cnt_r  <= 8'h00;
    end else begin
      low_slot_r <= cos_req_i;
      if (value_nxt != value_r && prio_r != dop_pkg::DOP_PRIO_NO) pend_r <= 1'b1;
      else if (int_due) pend_r <= 1'b1;
      else if (send_high || send_low || prio_r == dop_pkg::DOP_PRIO_NO) pend_r <= 1'b0;
      if (send_high || send_low || int_due) int_cnt_r <= 8'h00;
      else if (sec_go && int_cnt_r != 8'hff) int_cnt_r <= int_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rpt_valid_o <= 1'b0;
      rpt_high_o  <= 1'b0;
      rpt_value_o <= 8'h00;
    end else begin
      rpt_valid_o <= send_high || send_low;
      rpt_high_o  <= send_high;
      rpt_value_o <= value_r;
    end
  end

  // configuration checksum and condition code
  dop_crc16 #(.NBYTES(8)) u_crc (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .data_i ({maxint_r, dur_r, fb_r, act_r, deact_r, 3'h0, prio_r, pol_r, cnt_r, chan_r}),
    .crc_o  (crc)
  );

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      crc_ref_r <= 16'h0000;
      ref_set_r <= 1'b0;
      cfg_chg_r <= 1'b0;
    end else begin
      if (wr_crc) begin
        crc_ref_r <= wdata_i[15:0];
        ref_set_r <= 1'b1;
      end
      if (wr_cfg || wr_codes || wr_pulse || wr_maxint) cfg_chg_r <= 1'b1;
      else if (wr_crc) cfg_chg_r <= 1'b0;
    end
  end
  assign cond = (ref_set_r && crc_ref_r != crc) ? `DOP_COND_CRC_ERR :
                cfg_chg_r ? `DOP_COND_CHANGED : `DOP_COND_OK;

  // interrupts: set wins over write-one-clear
  assign irq_ev = {send_high || send_low, fb_go, pif.done, value_nxt != value_r};
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_stat_r <= 4'h0;
      irq_mask_r <= 4'h0;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_istat ? wdata_i[3:0] : 4'h0)) | irq_ev;
      if (wr_imask) irq_mask_r <= wdata_i[3:0];
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read port
  always_ff @(posedge mclk_i) begin
    if (rst_i) rdata_o <= 32'h0000_0000;
    else if (rd_i) begin
      if (addr_i == `DOP_OFF_CFG) rdata_o <= {10'h000, prio_r, 3'h0, pol_r, 4'h0, cnt_r, 2'h0, chan_r};
      else if (addr_i == `DOP_OFF_CODES) rdata_o <= {8'h00, fb_r, act_r, deact_r};
      else if (addr_i == `DOP_OFF_PULSE) rdata_o <= {16'h0000, dur_r};
      else if (addr_i == `DOP_OFF_MAXINT) rdata_o <= {24'h000000, maxint_r};
      else if (addr_i == `DOP_OFF_CMD) rdata_o <= {23'h000000, on_r, value_r};
      else if (addr_i == `DOP_OFF_STATUS) rdata_o <= {16'h0000, raw_bits, cond};
      else if (addr_i == `DOP_OFF_CRC) rdata_o <= {crc_ref_r, crc};
      else if (addr_i == `DOP_OFF_LASTCHG) rdata_o <= last_chg_r;
      else if (addr_i == `DOP_OFF_IRQ_STAT) rdata_o <= {28'h0000000, irq_stat_r};
      else if (addr_i == `DOP_OFF_IRQ_MASK) rdata_o <= {28'h0000000, irq_mask_r};
      else rdata_o <= 32'h0000_0000;
    end else rdata_o <= 32'h0000_0000;
  end

  // checks
  a_act_energise: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_cmd && wdata_i[7:0] == act_r && !fb_go |=>
    on_r ##1 chan_o == (chan_mask($past(chan_r), $past(cnt_r)) & {32{!$past(pol_r)}}))
    else $error("activate code did not energise");
  a_deact_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_go && value_nxt == deact_r && value_nxt != act_r |=> !on_r)
    else $error("deactivate code left output on");
  a_no_cmd_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !cmd_go |=> value_r == $past(value_r) && on_r == $past(on_r))
    else $error("output changed without a command");
  a_offline_fb: assert property (@(posedge mclk_i) disable iff (rst_i)
    comm_watchdog_point_present_i && offline_i && !offline_d_r |=> value_r == $past(fb_r))
    else $error("fallback value not applied");
  a_no_comm_watchdog_point: assert property (@(posedge mclk_i) disable iff (rst_i)
    !comm_watchdog_point_present_i && !wr_cmd && !cmd_valid_i && !pif.done |=> value_r == $past(value_r))
    else $error("offline changed value without watchdog");
  a_chan_window: assert property (@(posedge mclk_i) disable iff (rst_i)
    (chan_o & ~chan_mask($past(chan_r), $past(cnt_r))) == 32'h0000_0000)
    else $error("channel outside the assigned group driven");
  a_chan_legal: assert property (@(posedge mclk_i) disable iff (rst_i)
    chan_r >= `DOP_CHAN_MIN && chan_r <= `DOP_CHAN_MAX && cnt_r <= `DOP_CNT_MAX)
    else $error("channel setting out of range");
  a_pulse_end_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    pif.done && !fb_go && !wr_cmd && !cmd_valid_i |=> !on_r && value_r == deact_r)
    else $error("pulse end did not de-activate");
  a_no_report: assert property (@(posedge mclk_i) disable iff (rst_i)
    prio_r == dop_pkg::DOP_PRIO_NO |=> !rpt_valid_o)
    else $error("report sent with priority No");
  a_high_first: assert property (@(posedge mclk_i) disable iff (rst_i)
    cos_req_i && pend_r && prio_r == dop_pkg::DOP_PRIO_HIGH |=> rpt_valid_o && rpt_high_o)
    else $error("high report not in first slot");
  a_low_second: assert property (@(posedge mclk_i) disable iff (rst_i)
    rpt_valid_o && !rpt_high_o |-> $past(cos_req_i, 2))
    else $error("low report outside second slot");
  a_interval_due: assert property (@(posedge mclk_i) disable iff (rst_i)
    int_due |=> pend_r && int_cnt_r == 8'h00)
    else $error("interval resend not raised");
  a_cond_code: assert property (@(posedge mclk_i) disable iff (rst_i)
    cond == `DOP_COND_OK || cond == `DOP_COND_CHANGED || cond == `DOP_COND_CRC_ERR)
    else $error("illegal condition code");
  a_last_change: assert property (@(posedge mclk_i) disable iff (rst_i)
    value_nxt != value_r |=> last_chg_r == $past(sec_r))
    else $error("change time not recorded");

  c_pulse_run: cover property (@(posedge mclk_i) disable iff (rst_i) pif.load ##[1:1000] pif.done);
  c_high_report: cover property (@(posedge mclk_i) disable iff (rst_i) rpt_valid_o && rpt_high_o);
  c_low_report: cover property (@(posedge mclk_i) disable iff (rst_i) rpt_valid_o && !rpt_high_o);
  c_fallback: cover property (@(posedge mclk_i) disable iff (rst_i) fb_go);
endmodule // dop_ctrl
`default_nettype wire

// >>> hw/dop_params.svh
// Purpose: offsets, field positions, reset values and timing counts of the output point
// Assumes: byte addresses on the plain register port, 32-bit data
// Notes:   included by bare name
`ifndef DOP_PARAMS_SVH
`define DOP_PARAMS_SVH

`define DOP_ADDR_W        8
`define DOP_OFF_CFG       8'h00
`define DOP_OFF_CODES     8'h04
`define DOP_OFF_PULSE     8'h08
`define DOP_OFF_MAXINT    8'h0c
`define DOP_OFF_CMD       8'h10
`define DOP_OFF_STATUS    8'h14
`define DOP_OFF_CRC       8'h18
`define DOP_OFF_LASTCHG   8'h1c
`define DOP_OFF_IRQ_STAT  8'h20
`define DOP_OFF_IRQ_MASK  8'h24

`define DOP_CFG_CHAN_LSB  0
`define DOP_CFG_CNT_LSB   8
`define DOP_CFG_POL_BIT   16
`define DOP_CFG_PRIO_LSB  20
`define DOP_CODE_DEACT_LSB 0
`define DOP_CODE_ACT_LSB  8
`define DOP_CODE_FB_LSB   16

`define DOP_CHAN_MIN      6'h01
`define DOP_CHAN_MAX      6'h20
`define DOP_CNT_MAX       4'h8
`define DOP_CODE_OFF      8'h00
`define DOP_CODE_ON       8'h01
`define DOP_RST_CHAN      6'h01
`define DOP_RST_CNT       4'h1

`define DOP_COND_OK       8'h00
`define DOP_COND_CHANGED  8'h03
`define DOP_COND_CRC_ERR  8'h04

`define DOP_IRQ_CHANGE    0
`define DOP_IRQ_PULSE_END 1
`define DOP_IRQ_FALLBACK  2
`define DOP_IRQ_REPORT    3

`define DOP_CLK_KHZ       125000
`define DOP_TICK_MS       100
`define DOP_TICK_CYCLES   (`DOP_CLK_KHZ * `DOP_TICK_MS)
`define DOP_TICKS_PER_SEC 4'ha

`endif

// >>> hw/dop_pkg.sv
// Purpose: shared types of the output point
// Assumes: nothing
// Notes:   no constants here, see dop_params.svh
package dop_pkg;
  typedef enum logic [1:0] {DOP_PRIO_NO, DOP_PRIO_LOW, DOP_PRIO_HIGH} dop_prio_t;
endpackage

// >>> hw/dop_if.sv
// Purpose: link between the controller and its pulse timer
// Assumes: one clock
// Notes:   ctrl drives load, stop, duration and tick
`timescale 1ns/100ps
`default_nettype none
interface dop_if;
  logic        tick;
  logic        load;
  logic        stop;
  logic [15:0] dur;
  logic        busy;
  logic        done;
  modport ctrl  (output tick, output load, output stop, output dur, input busy, input done);
  modport timer (input tick, input load, input stop, input dur, output busy, output done);
endinterface
`default_nettype wire

// >>> hw/dop_pulse.sv
// Purpose: pulse timer counting tenths of a second
// Assumes: tick is a one-cycle pulse every 100 ms
// Notes:   done is a one-cycle pulse when the count runs out
`timescale 1ns/100ps
`default_nettype none
module dop_pulse (
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  dop_if.timer       pif
);
  logic [15:0] cnt_r;
  logic        busy_r;
  logic        done_r;

  assign pif.busy = busy_r;
  assign pif.done = done_r;

  // load, then one decrement per tick while active
  always_ff @(posedge mclk_i) begin
    if (rst_i || pif.stop) begin
      cnt_r  <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (pif.load) begin
      cnt_r  <= pif.dur;
      busy_r <= (pif.dur != 16'h0000);
      done_r <= 1'b0;
    end else if (busy_r && pif.tick) begin
      cnt_r  <= cnt_r - 16'h0001;
      busy_r <= (cnt_r != 16'h0001);
      done_r <= (cnt_r == 16'h0001);
    end else begin
      done_r <= 1'b0;
    end
  end

  a_pulse_load_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    pif.load && !pif.stop && pif.dur != 16'h0000 |=> busy_r && cnt_r == $past(pif.dur))
    else $error("pulse timer did not load");
  a_pulse_tick_dec: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy_r && pif.tick && !pif.load && !pif.stop |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("pulse count not decremented on tick");
  a_pulse_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy_r && !pif.tick && !pif.load && !pif.stop |=> cnt_r == $past(cnt_r) && !done_r)
    else $error("pulse count moved without a tick");
endmodule // dop_pulse
`default_nettype wire

// >>> hw/dop_crc16.sv
// Purpose: CRC-16 over the static configuration
// Assumes: reflected polynomial a001, initial value zero, low byte first
// Notes:   result registered one cycle after the configuration
`timescale 1ns/100ps
`default_nettype none
module dop_crc16 #(
  parameter int NBYTES = 8
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic [NBYTES*8-1:0]   data_i,
  output logic      [15:0]           crc_o
);
  function automatic logic [15:0] crc_calc(input logic [NBYTES*8-1:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < NBYTES * 8; i++) begin
      if (c[0] ^ d[i]) c = (c >> 1) ^ 16'ha001;
      else c = c >> 1;
    end
    return c;
  endfunction

  // checksum over configuration
  always_ff @(posedge mclk_i) begin
    if (rst_i) crc_o <= 16'h0000;
    else crc_o <= crc_calc(data_i);
  end
endmodule // dop_crc16
`default_nettype wire

// >>> tb/dop_host_model.sv
// Purpose: host and peer point model for the output point
// Assumes: one clock, requests change right after a rising edge
// Notes:   counts reports and stamps request and report cycles
`timescale 1ns/100ps
`default_nettype none
module dop_host_model (
  input  wire logic       mclk_i,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_value_o,
  output logic            cos_req_o,
  input  wire logic       rpt_valid_i,
  input  wire logic       rpt_high_i,
  input  wire logic [7:0] rpt_value_i
);
  int         cyc = 0;
  int         req_c = 0;
  int         rpt_c = 0;
  int         n_rpt = 0;
  logic       hi_seen = 1'b0;
  logic [7:0] val_seen = 8'h00;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_value_o = 8'h00;
    cos_req_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cos_req_o) begin
      req_c <= cyc;
    end
    if (rpt_valid_i) begin
      rpt_c <= cyc;
      n_rpt <= n_rpt + 1;
      hi_seen <= rpt_high_i;
      val_seen <= rpt_value_i;
    end
  end
  // a new value must be issued to cause any change
  task automatic send(input logic [7:0] v);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_value_o <= v;
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    cmd_value_o <= ~v;
  endtask
  task automatic ask();
    @(posedge mclk_i);
    cos_req_o <= 1'b1;
    @(posedge mclk_i);
    cos_req_o <= 1'b0;
  endtask
endmodule // dop_host_model
`default_nettype wire

// >>> tb/tb_dop_ctrl.sv
// Purpose: self-checking bench for the output point
// Assumes: tick shortened to 4 cycles, one second is 40 cycles
// Notes:   peer commands and host requests come from dop_host_model
`timescale 1ns/100ps
`default_nettype none
`include "dop_params.svh"
module tb_dop_ctrl;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        comm_watchdog_point_present_i = 1'b0;
  logic        offline_i = 1'b0;
  logic [31:0] rdata_o, chan_o, d;
  logic        cmd_valid_i, cos_req_i, rpt_valid_o, rpt_high_o, irq_o;
  logic [7:0]  cmd_value_i, rpt_value_o;
  logic [15:0] c;
  int          fail_count = 0;
  int          n_checks = 0;
  always #4 mclk_i = ~mclk_i;
  dop_ctrl #(.TICK_CYCLES(4)) uut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmd_valid_i(cmd_valid_i), .cmd_value_i(cmd_value_i),
    .comm_watchdog_point_present_i(comm_watchdog_point_present_i), .offline_i(offline_i), .cos_req_i(cos_req_i),
    .rpt_valid_o(rpt_valid_o), .rpt_high_o(rpt_high_o), .rpt_value_o(rpt_value_o), .chan_o(chan_o), .irq_o(irq_o));
  dop_host_model host (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid_i), .cmd_value_o(cmd_value_i),
    .cos_req_o(cos_req_i), .rpt_valid_i(rpt_valid_o), .rpt_high_i(rpt_high_o), .rpt_value_i(rpt_value_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc16_exp(input logic [63:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      if (r[0] ^ v[i]) r = (r >> 1) ^ 16'ha001;
      else r = r >> 1;
    end
    return r;
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic cmd_chk(input logic [7:0] v, input logic [31:0] e);
    host.send(v);
    wait_n(3);
    chk(chan_o, e);
  endtask
  task automatic ask_chk(input int k, input int lat, input logic hi, input logic [7:0] v);
    int n0;
    n0 = host.n_rpt;
    host.ask();
    wait_n(4);
    chk(32'(host.n_rpt - n0), 32'(k));
    if (k > 0) begin
      chk(32'(host.rpt_c - host.req_c), 32'(lat));
      chk({31'h0, host.hi_seen}, {31'h0, hi});
      chk({24'h0, host.val_seen}, {24'h0, v});
    end
  endtask
  task automatic t_reset();
    logic [7:0]  a[5] = '{`DOP_OFF_CFG, `DOP_OFF_CODES, `DOP_OFF_PULSE, `DOP_OFF_MAXINT, 8'h40};
    logic [31:0] e[5] = '{32'h0000_0101, 32'h0000_0100, 32'h0, 32'h0, 32'h0};
    foreach (a[i]) begin
      rd(a[i], d);
      chk(d, e[i]);
    end
    $display("reset values done");
  endtask
  task automatic t_drive();
    wr(`DOP_OFF_CFG, 32'h0000_0403);
    cmd_chk(`DOP_CODE_ON, 32'h0000_003c);
    cmd_chk(8'h55, 32'h0000_003c);
    rd(`DOP_OFF_CMD, d);
    chk(d, 32'h0000_0155);
    cmd_chk(`DOP_CODE_OFF, 32'h0);
    wr(`DOP_OFF_CFG, 32'h0001_0803);
    cmd_chk(`DOP_CODE_OFF, 32'h0000_03fc);
    wr(`DOP_OFF_CFG, 32'h0000_0121);
    wr(`DOP_OFF_CFG, 32'h0030_0903);
    rd(`DOP_OFF_CFG, d);
    chk(d, 32'h0000_0103);
    wr(`DOP_OFF_CFG, 32'h0000_0120);
    cmd_chk(`DOP_CODE_ON, 32'h8000_0000);
    wr(`DOP_OFF_CFG, 32'h0000_0003);
    cmd_chk(`DOP_CODE_ON, 32'h0);
    wr(`DOP_OFF_CFG, 32'h0000_0403);
    wr(`DOP_OFF_CMD, {24'h0, `DOP_CODE_OFF});
    wait_n(2);
    chk(chan_o, 32'h0);
    wr(`DOP_OFF_CMD, {24'h0, `DOP_CODE_ON});
    wait_n(2);
    chk(chan_o, 32'h0000_003c);
    $display("channel drive done");
  endtask
  task automatic t_pulse();
    wr(`DOP_OFF_CFG, 32'h0000_0101);
    wr(`DOP_OFF_PULSE, 32'h2);
    cmd_chk(`DOP_CODE_OFF, 32'h0);
    cmd_chk(`DOP_CODE_ON, 32'h1);
    wait_n(12);
    chk(chan_o, 32'h0);
    wr(`DOP_OFF_PULSE, 32'h0);
    $display("pulse done");
  endtask
  task automatic t_offline();
    wr(`DOP_OFF_CODES, 32'h0001_0100);
    @(posedge mclk_i) offline_i <= 1'b1;
    wait_n(4);
    chk(chan_o, 32'h0);
    @(posedge mclk_i) offline_i <= 1'b0;
    comm_watchdog_point_present_i <= 1'b1;
    wait_n(2);
    offline_i <= 1'b1;
    wait_n(4);
    chk(chan_o, 32'h1);
    offline_i <= 1'b0;
    $display("offline done");
  endtask
  task automatic t_report();
    wr(`DOP_OFF_CFG, 32'h0020_0101);
    host.send(`DOP_CODE_OFF);
    ask_chk(1, 1, 1'b1, `DOP_CODE_OFF);
    wr(`DOP_OFF_CFG, 32'h0010_0101);
    host.send(`DOP_CODE_ON);
    ask_chk(1, 2, 1'b0, `DOP_CODE_ON);
    wr(`DOP_OFF_CFG, 32'h0000_0101);
    host.send(`DOP_CODE_OFF);
    ask_chk(0, 0, 1'b0, 8'h00);
    wr(`DOP_OFF_MAXINT, 32'h1);
    wait_n(60);
    ask_chk(0, 0, 1'b0, 8'h00);
    wr(`DOP_OFF_CFG, 32'h0020_0101);
    wait_n(60);
    ask_chk(1, 1, 1'b1, `DOP_CODE_OFF);
    wr(`DOP_OFF_CFG, 32'h0000_0101);
    $display("reporting done");
  endtask
  task automatic t_cond_irq();
    wr(`DOP_OFF_IRQ_STAT, 32'hf);
    wr(`DOP_OFF_IRQ_MASK, 32'h1);
    rd(`DOP_OFF_LASTCHG, d);
    c = d[15:0];
    wait_n(3);
    chk({31'h0, irq_o}, 32'h0);
    wait_n(100);
    host.send(`DOP_CODE_ON);
    wait_n(4);
    chk({31'h0, irq_o}, 32'h1);
    rd(`DOP_OFF_LASTCHG, d);
    chk({31'h0, d[15:0] > c}, 32'h1);
    wr(`DOP_OFF_IRQ_STAT, 32'h1);
    wait_n(3);
    chk({31'h0, irq_o}, 32'h0);
    rd(`DOP_OFF_CRC, d);
    c = d[15:0];
    chk({16'h0, c}, {16'h0, crc16_exp(64'h0100_0001_0100_0041)});
    wr(`DOP_OFF_CRC, {16'h0, c});
    rd(`DOP_OFF_STATUS, d);
    chk(d[15:0], {8'h01, `DOP_COND_OK});
    wr(`DOP_OFF_CRC, {16'h0, c ^ 16'h0001});
    rd(`DOP_OFF_STATUS, d);
    chk({24'h0, d[7:0]}, {24'h0, `DOP_COND_CRC_ERR});
    wr(`DOP_OFF_CRC, {16'h0, c});
    wr(`DOP_OFF_PULSE, 32'h0);
    wait_n(2);
    rd(`DOP_OFF_STATUS, d);
    chk({24'h0, d[7:0]}, {24'h0, `DOP_COND_CHANGED});
    wr(`DOP_OFF_PULSE, 32'h5);
    wait_n(2);
    rd(`DOP_OFF_STATUS, d);
    chk({24'h0, d[7:0]}, {24'h0, `DOP_COND_CRC_ERR});
    rd(`DOP_OFF_CRC, d);
    chk({31'h0, d[15:0] !== c}, 32'h1);
    chk({16'h0, d[15:0]}, {16'h0, crc16_exp(64'h0100_0501_0100_0041)});
    $display("condition and interrupt done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_drive();
    t_pulse();
    t_offline();
    t_report();
    t_cond_irq();
    stop_test();
  end
endmodule // tb_dop_ctrl
`default_nettype wire
